/* File: dv/pipe_model.sv */
// Integer pipeline model: encodes instructions and moves words over APB.
`timescale 1ns/1ns
`default_nettype none
module pipe_model (
  // Clock
  input  wire logic        mclk_i,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // The request is held until the edge that sees pready high; a new
  // setup starts one edge after release so no signal is driven twice.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask

  function automatic logic [31:0] mv(input logic [4:0] op,
                                     input logic [4:0] sel);
    return {fpcw_pkg::OP_FPU, op, 5'h00, sel, 11'h000};
  endfunction

  // Operands are always stored in the format that the word names.
  function automatic logic [31:0] ceil(input logic [4:0] f);
    return {fpcw_pkg::OP_FPU, f, 5'h00, 5'h01, 5'h02, fpcw_pkg::FN_CEIL_W};
  endfunction
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking testbench for the floating point control word block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        mclk_i;
  logic        rst_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_o;
  logic [31:0] q;
  logic        e;
  int          mismatches = 0;
  int          n_compared = 0;

  fp_control_word DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
  pipe_model pipe (.mclk_i(mclk_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial mclk_i = 1'b0;
  always #50 mclk_i = ~mclk_i;

  task automatic chk32(input string n, input logic [31:0] x,
                       input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk1(input string n, input logic x, input logic g);
    chk32(n, {31'h0, x}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    pipe.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    pipe.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic csr_chk(input logic [31:0] x);
    rd(fpcw_pkg::A_CSR);
    chk32("control status", x, q);
  endtask
  // Status bits 3..1 are compared; the mask lets all three reach irq_o.
  task automatic issue(input logic [31:0] ins, input logic [2:0] ex);
    wr(fpcw_pkg::A_INSTR, ins);
    do rd(fpcw_pkg::A_BUSY); while (q[0] !== 1'b0);
    chk1("irq_o", |ex, irq_o);
    rd(fpcw_pkg::A_STAT);
    chk32("stat", {29'h0, ex}, {29'h0, q[3:1]});
    repeat (3) @(posedge mclk_i);
    chk1("irq_o clear", 1'b0, irq_o);
  endtask
  task automatic cw(input logic [4:0] s, input logic [31:0] v,
                    input logic [2:0] ex);
    wr(fpcw_pkg::A_GP_IN, v);
    issue(pipe.mv(fpcw_pkg::RS_WRCTL, s), ex);
  endtask
  task automatic cr(input logic [4:0] s, input logic [31:0] lo);
    issue(pipe.mv(fpcw_pkg::RS_RDCTL, s), 3'b000);
    rd(fpcw_pkg::A_RES_LO);
    chk32("result lo", lo, q);
    rd(fpcw_pkg::A_RES_HI);
    chk32("result hi", {32{lo[31]}}, q);
  endtask
  task automatic cl(input logic [4:0] f, input logic [63:0] v,
                    input logic [31:0] w, input logic [2:0] ex);
    wr(fpcw_pkg::A_FR_SEL, 32'h1);
    wr(fpcw_pkg::A_FR_LO, v[31:0]);
    wr(fpcw_pkg::A_FR_HI, v[63:32]);
    wr(fpcw_pkg::A_FR_SEL, 32'h2);
    wr(fpcw_pkg::A_FR_LO, 32'hA5A5_5A5A);
    wr(fpcw_pkg::A_FR_HI, 32'h0);
    issue(pipe.ceil(f), ex);
    rd(fpcw_pkg::A_FR_LO);
    chk32("ceil word", w, q);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_access;
    csr_chk(fpcw_pkg::CSR_RST);
    chk1("irq_o reset", 1'b0, irq_o);
    wr(fpcw_pkg::A_MASK, 32'hE);
    issue(pipe.mv(fpcw_pkg::RS_RDCTL, 5'd31), 3'b100);
    wr(fpcw_pkg::A_CTRL, 32'h1);
    issue(pipe.mv(5'h05, 5'd31), 3'b010);
    issue(pipe.ceil(5'h14), 3'b010);
    issue(pipe.ceil(fpcw_pkg::FMT_S) | 32'h0001_0000, 3'b010);
    rd(8'h30);
    chk1("unmapped err", 1'b1, e);
    chk32("unmapped data", 32'h0, q);
    $display("t_access done");
  endtask
  task automatic t_views;
    cw(fpcw_pkg::SEL_FULL, 32'hFF80_2E7F, 3'b000);
    cr(fpcw_pkg::SEL_FULL, 32'hFF80_2E7F);
    cr(fpcw_pkg::SEL_ID, fpcw_pkg::FP_IMPL_ID);
    cr(fpcw_pkg::SEL_COND, 32'h0000_00FF);
    cr(fpcw_pkg::SEL_EXC, 32'h0000_207C);
    cr(fpcw_pkg::SEL_ENA, 32'h0000_0E07);
    cr(5'd3, 32'h0000_0000);
    cw(fpcw_pkg::SEL_COND, 32'h0, 3'b000);
    csr_chk(32'h0100_2E7F);
    cw(fpcw_pkg::SEL_ENA, 32'h0, 3'b000);
    csr_chk(32'h0000_207C);
    cw(fpcw_pkg::SEL_EXC, 32'h0, 3'b000);
    csr_chk(32'h0);
    $display("t_views done");
  endtask
  task automatic t_trap;
    cw(fpcw_pkg::SEL_FULL, 32'h0000_0800, 3'b000);
    cw(fpcw_pkg::SEL_EXC, 32'h0001_0000, 3'b001);
    csr_chk(32'h0001_0800);
    cw(fpcw_pkg::SEL_FULL, 32'h0001_0000, 3'b000);
    cw(fpcw_pkg::SEL_ENA, 32'h0000_0800, 3'b001);
    cw(fpcw_pkg::SEL_FULL, 32'h0001_0800, 3'b001);
    csr_chk(32'h0001_0800);
    cw(fpcw_pkg::SEL_FULL, 32'h0002_0000, 3'b001);
    $display("t_trap done");
  endtask
  task automatic t_ceil;
    // Round toward zero is selected so that an upward result stands out.
    cw(fpcw_pkg::SEL_FULL, 32'h0000_0001, 3'b000);
    cl(fpcw_pkg::FMT_S, 64'h3FC0_0000, 32'h0000_0002, 3'b000);
    cl(fpcw_pkg::FMT_S, 64'hBFC0_0000, 32'hFFFF_FFFF, 3'b000);
    cl(fpcw_pkg::FMT_D, 64'h4002_0000_0000_0000, 32'h3, 3'b000);
    cl(fpcw_pkg::FMT_S, 64'hCF00_0000, 32'h8000_0000, 3'b000);
    cl(fpcw_pkg::FMT_S, 64'h4F00_0000, 32'h7FFF_FFFF, 3'b000);
    cl(fpcw_pkg::FMT_S, 64'h7FC0_0000, 32'h7FFF_FFFF, 3'b000);
    csr_chk(32'h0001_0045);
    cw(fpcw_pkg::SEL_FULL, 32'h0000_0801, 3'b000);
    cl(fpcw_pkg::FMT_S, 64'h7F80_0000, 32'hA5A5_5A5A, 3'b001);
    $display("t_ceil done");
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_access;
    t_views;
    t_trap;
    t_ceil;
    conclude;
  end

  initial begin
    #(100 * 20000);
    mismatches++;
    conclude;
  end
endmodule
`default_nettype wire

/* File: verilog/fp_control_word.sv */
// FPU control word moves, partial views and ceiling-to-word conversion.
//
// Operation
// - Ceiling convert to signed word, always upward.
// - Infinity, NaN or out-of-range sets invalid.
// - Invalid enabled traps; else writes 2^31-1.
// - Conversion raises FP and instruction exceptions.
// - Control read sign-extends word to 64 bits.
// - Selector 0 identity, 31 full register.
// - Selectors 25, 26, 28 give packed views.
// - Control write stores low source word.
// - Enabled cause after write raises exception.
// - View writes completing a pair raise exception.
// - Control write reports FP and instruction exceptions.
`timescale 1ns/1ns
`default_nettype none
module fp_control_word (
  // Clock and reset
  input  wire  logic        mclk_i,
  input  wire  logic        rst_i,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // Interrupt
  output logic              irq_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    fpcw_pkg::exec_state_t st;
    logic [31:0] instr;
    logic [31:0] gp_in;
    logic [63:0] res;
    logic        usable;
    logic [4:0]  fr_sel;
    logic [31:0] fr_lo;
    logic [31:0] csr;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic        we;
  logic [4:0]  waddr;
  logic [63:0] wdata;
  logic [4:0]  raddr;
  logic [63:0] rdata;

  fp_reg_file u_freg (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .we_i    (we),
    .waddr_i (waddr),
    .wdata_i (wdata),
    .raddr_i (raddr),
    .rdata_o (rdata)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [4:0] rs_f;
  logic [4:0] sel;
  logic       is_rd;
  logic       is_wr;
  logic       is_ceil;
  assign rs_f  = s_r.instr[25:21];
  assign sel   = s_r.instr[15:11];
  assign is_rd = s_r.instr[31:26] == fpcw_pkg::OP_FPU
              && rs_f == fpcw_pkg::RS_RDCTL && s_r.instr[10:0] == 11'h000;
  assign is_wr = s_r.instr[31:26] == fpcw_pkg::OP_FPU
              && rs_f == fpcw_pkg::RS_WRCTL && s_r.instr[10:0] == 11'h000;
  assign is_ceil = s_r.instr[31:26] == fpcw_pkg::OP_FPU
                && (rs_f == fpcw_pkg::FMT_S || rs_f == fpcw_pkg::FMT_D)
                && s_r.instr[20:16] == 5'h00
                && s_r.instr[5:0] == fpcw_pkg::FN_CEIL_W;
  assign raddr = (s_r.st == fpcw_pkg::S_IDLE) ? s_r.fr_sel
                                              : s_r.instr[15:11];

  // ****************************************************************
  // Ceiling conversion
  // ****************************************************************
  // Truncation of the magnitude already rounds negatives upward, so
  // only positive values with a fraction need the extra one.
  logic        cv_sgn;
  logic        cv_inv;
  logic        cv_inx;
  logic [31:0] cv_res;
  always_comb begin
    logic        sgl;
    logic [10:0] ef;
    logic [52:0] man;
    logic signed [12:0] e;
    logic [32:0] ip;
    logic [32:0] r;
    logic        frac;
    logic        big;
    sgl  = rs_f == fpcw_pkg::FMT_S;
    ef   = sgl ? {3'h0, rdata[30:23]} : rdata[62:52];
    man  = sgl ? {ef != 11'h000, rdata[22:0], 29'h0}
               : {ef != 11'h000, rdata[51:0]};
    e    = sgl ? $signed({2'h0, ef}) - 13'sd127
               : $signed({2'h0, ef}) - 13'sd1023;
    cv_sgn = sgl ? rdata[31] : rdata[63];
    ip   = 33'h0;
    frac = 1'b0;
    big  = sgl ? (ef == 11'h0FF) : (ef == 11'h7FF);
    if (e < 13'sd0) begin
      frac = |man;
    end else if (e > 13'sd31) begin
      big = 1'b1;
    end else begin
      ip   = 33'(man >> (6'd52 - 6'(e)));
      frac = |(53'(man << (6'(e) + 6'd1)));
    end
    r = cv_sgn ? 33'(-ip) : 33'(ip + {32'h0, frac});
    cv_inv = big || (cv_sgn ? (ip > fpcw_pkg::NEG_LIMIT)
                            : (r > fpcw_pkg::POS_LIMIT));
    cv_inx = frac && !cv_inv;
    cv_res = cv_inv ? fpcw_pkg::DEFAULT_WORD : r[31:0];
  end

  // ****************************************************************
  // Control views
  // ****************************************************************
  logic [31:0] f;
  logic [31:0] t;
  logic [31:0] rd_view;
  logic [31:0] wr_view;
  logic        wr_trap;
  assign f = s_r.csr;
  assign t = s_r.gp_in;
  always_comb begin
    case (sel)
      fpcw_pkg::SEL_ID:   rd_view = fpcw_pkg::FP_IMPL_ID;
      fpcw_pkg::SEL_COND: rd_view = {24'h0, f[31:25], f[23]};
      fpcw_pkg::SEL_EXC:
        rd_view = {14'h0, f[17:12], 5'h00, f[6:2], 2'h0};
      fpcw_pkg::SEL_ENA:
        rd_view = {20'h0, f[11:7], 4'h0, f[24], f[1:0]};
      fpcw_pkg::SEL_FULL: rd_view = f;
      default:            rd_view = 32'h0000_0000;
    endcase
    case (sel)
      fpcw_pkg::SEL_COND: wr_view = {t[7:1], f[24], t[0], f[22:0]};
      fpcw_pkg::SEL_EXC:
        wr_view = {f[31:18], t[17:12], f[11:7], t[6:2], f[1:0]};
      fpcw_pkg::SEL_ENA:
        wr_view = {f[31:25], t[2], f[23:12], t[11:7], f[6:2], t[1:0]};
      fpcw_pkg::SEL_FULL: wr_view = t;
      default:            wr_view = f;
    endcase
    // Checked on the new value, which covers both view writes.
    wr_trap = |(wr_view[16:12] & wr_view[11:7])
            || wr_view[fpcw_pkg::CAUSE_UNI];
  end

  // ****************************************************************
  // Conversion result into the control/status register
  // ****************************************************************
  logic [5:0]  cv_cause;
  logic [31:0] cv_fp_control_status;
  logic        cv_trap;
  always_comb begin
    cv_cause = 6'h00;
    cv_cause[fpcw_pkg::B_INV] = cv_inv;
    cv_cause[fpcw_pkg::B_INX] = cv_inx;
    cv_fp_control_status = f;
    cv_fp_control_status[17:12] = cv_cause;
    cv_fp_control_status[6:2]   = f[6:2] | cv_cause[4:0];
    cv_trap = |(cv_cause[4:0] & f[11:7]);
  end

  // ****************************************************************
  // Bus, sequencing and events
  // ****************************************************************
  logic acc;
  logic wfire;
  logic rfire;
  logic busy;
  logic mapped;
  assign busy   = s_r.st != fpcw_pkg::S_IDLE;
  assign acc    = psel && penable && !s_r.pready;
  assign wfire  = psel && penable && s_r.pready && pwrite;
  assign rfire  = psel && penable && s_r.pready && !pwrite;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= fpcw_pkg::A_BUSY;

  always_comb begin
    logic [3:0] ev;
    logic       refuse;
    s_nxt = s_r;
    ev = 4'h0;
    we = 1'b0;
    waddr = s_r.fr_sel;
    wdata = {pwdata, s_r.fr_lo};
    refuse = busy && (paddr == fpcw_pkg::A_INSTR
                   || paddr == fpcw_pkg::A_FR_HI
                   || paddr == fpcw_pkg::A_FR_SEL);
    s_nxt.pready = acc;
    s_nxt.pslverr = acc && (!mapped || (pwrite && refuse));
    if (acc) begin
      case (paddr)
        fpcw_pkg::A_CTRL:    s_nxt.prdata = {31'h0, s_r.usable};
        fpcw_pkg::A_INSTR:   s_nxt.prdata = s_r.instr;
        fpcw_pkg::A_GP_IN:   s_nxt.prdata = s_r.gp_in;
        fpcw_pkg::A_RES_LO:  s_nxt.prdata = s_r.res[31:0];
        fpcw_pkg::A_RES_HI:  s_nxt.prdata = s_r.res[63:32];
        fpcw_pkg::A_FR_SEL:  s_nxt.prdata = {27'h0, s_r.fr_sel};
        fpcw_pkg::A_FR_LO:   s_nxt.prdata = rdata[31:0];
        fpcw_pkg::A_FR_HI:   s_nxt.prdata = rdata[63:32];
        fpcw_pkg::A_CSR:     s_nxt.prdata = s_r.csr;
        fpcw_pkg::A_STAT:    s_nxt.prdata = {28'h0, s_r.stat};
        fpcw_pkg::A_MASK:    s_nxt.prdata = {28'h0, s_r.mask};
        fpcw_pkg::A_BUSY:    s_nxt.prdata = {31'h0, busy};
        default:             s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (wfire && !s_r.pslverr) begin
      case (paddr)
        fpcw_pkg::A_CTRL:    s_nxt.usable = pwdata[0];
        fpcw_pkg::A_GP_IN:   s_nxt.gp_in = pwdata;
        fpcw_pkg::A_FR_SEL:  s_nxt.fr_sel = pwdata[4:0];
        fpcw_pkg::A_FR_LO:   s_nxt.fr_lo = pwdata;
        fpcw_pkg::A_FR_HI:   we = 1'b1;
        fpcw_pkg::A_MASK:    s_nxt.mask = pwdata[3:0];
        fpcw_pkg::A_INSTR: begin
          s_nxt.instr = pwdata;
          s_nxt.st = fpcw_pkg::S_DECODE;
        end
        default: ;
      endcase
    end
    case (s_r.st)
      fpcw_pkg::S_IDLE: ;
      fpcw_pkg::S_DECODE: begin
        s_nxt.st = fpcw_pkg::S_IDLE;
        ev[fpcw_pkg::ST_DONE] = 1'b1;
        if (!s_r.usable) begin
          ev[fpcw_pkg::ST_CPU] = 1'b1;
        end else if (is_rd) begin
          s_nxt.res = {{32{rd_view[31]}}, rd_view};
        end else if (is_wr) begin
          s_nxt.csr = wr_view;
          ev[fpcw_pkg::ST_FPE] = wr_trap;
        end else if (is_ceil) begin
          s_nxt.st = fpcw_pkg::S_EXEC;
          ev[fpcw_pkg::ST_DONE] = 1'b0;
        end else begin
          ev[fpcw_pkg::ST_RI] = 1'b1;
        end
      end
      fpcw_pkg::S_EXEC: begin
        s_nxt.st = fpcw_pkg::S_IDLE;
        s_nxt.csr = cv_fp_control_status;
        ev[fpcw_pkg::ST_DONE] = 1'b1;
        ev[fpcw_pkg::ST_FPE] = cv_trap;
        we = !cv_trap;
        waddr = s_r.instr[10:6];
        wdata = {32'h0000_0000, cv_res};
      end
      default: s_nxt.st = fpcw_pkg::S_IDLE;
    endcase
    // Only bits that the read reported are cleared, so an event that
    // lands between the data latch and the clear edge is not lost.
    if (rfire && paddr == fpcw_pkg::A_STAT) begin
      s_nxt.stat = (s_r.stat & ~s_r.prdata[3:0]) | ev;
    end else begin
      s_nxt.stat = s_r.stat | ev;
    end
    s_nxt.irq = |(s_nxt.stat & s_r.mask);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.st <= fpcw_pkg::S_IDLE;
      s_r.csr <= fpcw_pkg::CSR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq_o   = s_r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic dec_ok;
  assign dec_ok = s_r.st == fpcw_pkg::S_DECODE && s_r.usable;

  property p_ceil_wr;
    @(posedge mclk_i) disable iff (rst_i)
    (s_r.st == fpcw_pkg::S_EXEC && !cv_trap)
      |-> we && waddr == s_r.instr[10:6] && wdata[63:32] == 32'h0;
  endproperty
  a_ceil_wr: assert property (p_ceil_wr)
    else $error("ceiling result not written to destination");

  property p_inv_flag;
    @(posedge mclk_i) disable iff (rst_i)
    (s_r.st == fpcw_pkg::S_EXEC && cv_inv)
      |=> s_r.csr[6] && s_r.csr[16] && s_r.st == fpcw_pkg::S_IDLE;
  endproperty
  a_inv_flag: assert property (p_inv_flag)
    else $error("invalid conversion did not set flag and cause");

  property p_inv_trap;
    @(posedge mclk_i) disable iff (rst_i)
    (s_r.st == fpcw_pkg::S_EXEC && cv_inv && s_r.csr[11])
      |-> !we ##1 s_r.stat[fpcw_pkg::ST_FPE];
  endproperty
  a_inv_trap: assert property (p_inv_trap)
    else $error("enabled invalid conversion wrote or did not trap");

  property p_inv_dflt;
    @(posedge mclk_i) disable iff (rst_i)
    (s_r.st == fpcw_pkg::S_EXEC && cv_inv && s_r.csr[11:7] == 5'h00)
      |-> we && wdata[31:0] == 32'h7FFF_FFFF;
  endproperty
  a_inv_dflt: assert property (p_inv_dflt)
    else $error("masked invalid conversion lacks default word");

  property p_cpu_unusable;
    @(posedge mclk_i) disable iff (rst_i)
    (s_r.st == fpcw_pkg::S_DECODE && !s_r.usable)
      |=> s_r.stat[fpcw_pkg::ST_CPU] && $stable(s_r.csr);
  endproperty
  a_cpu_unusable: assert property (p_cpu_unusable)
    else $error("unusable coprocessor not reported");

  property p_rd_ext;
    @(posedge mclk_i) disable iff (rst_i)
    (dec_ok && is_rd) |=> s_r.res[63:32] == {32{s_r.res[31]}};
  endproperty
  a_rd_ext: assert property (p_rd_ext)
    else $error("control read not sign extended");

  property p_rd_full;
    @(posedge mclk_i) disable iff (rst_i)
    (dec_ok && is_rd && sel == 5'd31)
      |=> s_r.res[31:0] == $past(s_r.csr);
  endproperty
  a_rd_full: assert property (p_rd_full)
    else $error("selector 31 did not return full register");

  property p_rd_ena;
    @(posedge mclk_i) disable iff (rst_i)
    (dec_ok && is_rd && sel == 5'd28)
      |=> s_r.res[2] == $past(s_r.csr[24])
       && s_r.res[11:7] == $past(s_r.csr[11:7]);
  endproperty
  a_rd_ena: assert property (p_rd_ena)
    else $error("enable view packed wrongly");

  property p_wr_exc;
    @(posedge mclk_i) disable iff (rst_i)
    (dec_ok && is_wr && sel == 5'd26)
      |=> s_r.csr[11:7] == $past(s_r.csr[11:7])
       && s_r.csr[31:18] == $past(s_r.csr[31:18]);
  endproperty
  a_wr_exc: assert property (p_wr_exc)
    else $error("exception view write touched hidden bits");

  property p_wr_trap;
    @(posedge mclk_i) disable iff (rst_i)
    (dec_ok && is_wr && sel == 5'd31 && |(t[16:12] & t[11:7]))
      |=> s_r.csr == $past(t) && s_r.stat[fpcw_pkg::ST_FPE];
  endproperty
  a_wr_trap: assert property (p_wr_trap)
    else $error("enabled cause after write raised no exception");
endmodule
`default_nettype wire

/* File: verilog/fp_reg_file.sv */
// Floating point register file with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module fp_reg_file (
  // Clock and reset
  input  wire  logic        mclk_i,
  input  wire  logic        rst_i,
  // Write port
  input  wire  logic        we_i,
  input  wire  logic [4:0]  waddr_i,
  input  wire  logic [63:0] wdata_i,
  // Read port
  input  wire  logic [4:0]  raddr_i,
  output logic       [63:0] rdata_o
);
  logic [63:0] mem_r [0:31];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 64'h0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule
`default_nettype wire

/* File: verilog/fpcw_pkg.sv */
// Constants and types shared by the floating point control word block.
`default_nettype none
package fpcw_pkg;
  // ****************************************************************
  // Bus register offsets
  // ****************************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_INSTR  = 8'h04;
  localparam logic [7:0] A_GP_IN  = 8'h08;
  localparam logic [7:0] A_RES_LO = 8'h0C;
  localparam logic [7:0] A_RES_HI = 8'h10;
  localparam logic [7:0] A_FR_SEL = 8'h14;
  localparam logic [7:0] A_FR_LO  = 8'h18;
  localparam logic [7:0] A_FR_HI  = 8'h1C;
  localparam logic [7:0] A_CSR    = 8'h20;
  localparam logic [7:0] A_STAT   = 8'h24;
  localparam logic [7:0] A_MASK   = 8'h28;
  localparam logic [7:0] A_BUSY   = 8'h2C;
  // ****************************************************************
  // Reset values, identity and fixed results
  // ****************************************************************
  localparam logic [31:0] CSR_RST      = 32'h0000_0000;
  // Arbitrary identity value.
  localparam logic [31:0] FP_IMPL_ID   = 32'h0001_0A00;
  localparam logic [31:0] DEFAULT_WORD = 32'h7FFF_FFFF;
  localparam logic [32:0] POS_LIMIT    = 33'h0_7FFF_FFFF;
  localparam logic [32:0] NEG_LIMIT    = 33'h0_8000_0000;
  // ****************************************************************
  // Instruction encodings and selectors
  // ****************************************************************
  localparam logic [5:0] OP_FPU    = 6'h11;
  localparam logic [4:0] RS_RDCTL  = 5'h02;
  localparam logic [4:0] RS_WRCTL  = 5'h06;
  localparam logic [4:0] FMT_S     = 5'h10;
  localparam logic [4:0] FMT_D     = 5'h11;
  localparam logic [5:0] FN_CEIL_W = 6'h0E;
  localparam logic [4:0] SEL_ID    = 5'd0;
  localparam logic [4:0] SEL_COND  = 5'd25;
  localparam logic [4:0] SEL_EXC   = 5'd26;
  localparam logic [4:0] SEL_ENA   = 5'd28;
  localparam logic [4:0] SEL_FULL  = 5'd31;
  // ****************************************************************
  // Control/status fields and event bits
  // ****************************************************************
  localparam int FLAG_LSB  = 2;
  localparam int ENA_LSB   = 7;
  localparam int CAUSE_LSB = 12;
  localparam int CAUSE_UNI = 17;
  localparam int B_INX     = 0;
  localparam int B_INV     = 4;
  localparam int ST_DONE   = 0;
  localparam int ST_FPE    = 1;
  localparam int ST_RI     = 2;
  localparam int ST_CPU    = 3;
  typedef enum logic [1:0] {S_IDLE, S_DECODE, S_EXEC} exec_state_t;
endpackage
`default_nettype wire
